// [src/power_manager_pin_control.sv]
// pin-level control and fault handling of the power manager
// assumes i_mem_write_req, i_tx_bit_valid and i_tx_bit are synchronous to i_clk_sys; open-drain pins split into in, out and enable
module power_manager_pin_control (
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  input  wire logic       i_cold_restart_n,
  input  wire logic       i_soft_restart_n,
  input  wire logic       i_mains_loss_n,
  input  wire logic       i_write_lock_n,
  input  wire logic [2:0] i_addr_strap,
  input  wire logic [3:0] i_irq_n,
  input  wire logic [3:0] i_irq_hot_swap,
  input  wire logic [3:0] i_group_health_in,
  input  wire logic [3:0] i_aux_power_good,
  input  wire logic       i_intermediate_bus_over,
  input  wire logic       i_mem_write_req,
  input  wire logic       i_sync_data_in,
  input  wire logic       i_tx_bit_valid,
  input  wire logic       i_tx_bit,
  output logic [6:0]      o_bus_addr,
  output logic            o_overvoltage_trigger,
  output logic [3:0]      o_aux_enable,
  output logic            o_front_end_on,
  output logic [3:0]      o_group_health_out,
  output logic [3:0]      o_group_health_oe,
  output logic [3:0]      o_group_fault,
  output logic [3:0]      o_aux_status,
  output logic [3:0]      o_group_program,
  output logic [3:0]      o_group_disconnected,
  output logic            o_mem_write_en,
  output logic            o_mem_write_rejected,
  output logic            o_sync_data_out,
  output logic            o_sync_data_oe,
  output logic            o_rx_bit,
  output logic            o_shutdown
);
  // ----------------------------------------------------------------
  // reset and input synchronisers
  // ----------------------------------------------------------------
  logic        rst_n;
  logic [1:0]  cold_sync_q;
  logic [20:0] s1_q;
  logic [20:0] s2_q;
  logic [20:0] raw;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cold_sync_q <= 2'h0;
    end else begin
      cold_sync_q <= {cold_sync_q[0], i_cold_restart_n};
    end
  end
  assign rst_n = cold_sync_q[1];
  assign raw = {i_soft_restart_n, i_mains_loss_n, i_write_lock_n, i_irq_n, i_group_health_in,
                i_aux_power_good, i_intermediate_bus_over, i_sync_data_in, i_irq_hot_swap};
  // two-flop synchroniser; inactive-high reset idles active-low pins
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_q <= 21'h1fffd0;
      s2_q <= 21'h1fffd0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  logic       soft_n;
  logic       mains_n;
  logic       lock_n;
  logic [3:0] irq_n;
  logic [3:0] health;
  logic [3:0] pgood;
  logic       ov;
  logic       sd_in;
  logic [3:0] hot;
  assign {soft_n, mains_n, lock_n, irq_n, health, pgood, ov, sd_in, hot} = s2_q;
  // ----------------------------------------------------------------
  // address strap and status
  // ----------------------------------------------------------------
  logic addr_taken_q;
  // strap caught once after reset release
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_bus_addr   <= pm_pins_pkg::BUS_ADDR_RST;
      addr_taken_q <= 1'b0;
    end else if (!addr_taken_q) begin
      o_bus_addr   <= {pm_pins_pkg::BUS_ADDR_BASE[6:3], i_addr_strap};
      addr_taken_q <= 1'b1;
    end
  end
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_aux_status <= pm_pins_pkg::MASK_RST;
    end else begin
      o_aux_status <= pgood;
    end
  end
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  pm_pins_pkg::seq_state_t st_q;
  logic [4:0] step_q;
  logic [1:0] idx_q;
  logic       step_done;
  logic [3:0] halt;
  logic [3:0] self_pull;
  assign step_done = (step_q == 5'(pm_pins_pkg::STEP_CYC - 1));
  // halt-mode interrupts act on the group health lines
  assign halt = ~irq_n & ~hot;
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q           <= pm_pins_pkg::ST_COLD;
      step_q         <= pm_pins_pkg::STEP_CNT_RST;
      idx_q          <= pm_pins_pkg::IDX_RST;
      o_aux_enable   <= pm_pins_pkg::MASK_RST;
      o_front_end_on <= 1'b0;
      o_shutdown     <= 1'b0;
    end else if (!mains_n) begin
      st_q           <= pm_pins_pkg::ST_SHUTDOWN;
      o_aux_enable   <= pm_pins_pkg::MASK_RST;
      o_front_end_on <= 1'b0;
      o_shutdown     <= 1'b1;
    end else begin
      step_q <= step_done ? pm_pins_pkg::STEP_CNT_RST : step_q + 5'h01;
      unique case (st_q)
        pm_pins_pkg::ST_COLD, pm_pins_pkg::ST_SHUTDOWN: begin
          o_shutdown <= 1'b0;
          if (soft_n) begin
            st_q  <= pm_pins_pkg::ST_PROGRAM;
            idx_q <= pm_pins_pkg::IDX_RST;
          end
        end
        pm_pins_pkg::ST_PROGRAM: begin
          // front end first, then aux enables one per step
          o_front_end_on <= 1'b1;
          if (!soft_n) begin
            st_q <= pm_pins_pkg::ST_SEQ_OFF;
          end else if (step_done) begin
            o_aux_enable[idx_q] <= 1'b1;
            idx_q <= idx_q + 2'h1;
            if (idx_q == 2'h3) begin
              st_q <= pm_pins_pkg::ST_RUN;
            end
          end
        end
        pm_pins_pkg::ST_RUN: begin
          if (!soft_n) begin
            st_q  <= pm_pins_pkg::ST_SEQ_OFF;
            idx_q <= 2'h3;
          end
        end
        pm_pins_pkg::ST_SEQ_OFF: begin
          if (step_done) begin
            o_aux_enable[idx_q] <= 1'b0;
            idx_q <= idx_q - 2'h1;
            if (idx_q == 2'h0) begin
              st_q <= pm_pins_pkg::ST_WAIT_RELEASE;
            end
          end
        end
        pm_pins_pkg::ST_WAIT_RELEASE: begin
          if (soft_n) begin
            st_q  <= pm_pins_pkg::ST_PROGRAM;
            idx_q <= pm_pins_pkg::IDX_RST;
          end
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // group health lines, faults, hot swap
  // ----------------------------------------------------------------
  // pull low while halted or in any state other than run (cold, program, sequencing off, wait release, shut down)
  assign self_pull = halt | {4{st_q != pm_pins_pkg::ST_RUN}};
  logic [3:0] irq_prev_q;
  logic [3:0] oe_d1_q;
  logic [3:0] oe_d2_q;
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_group_health_out <= 4'h0;
      o_group_health_oe  <= 4'hf;
      oe_d1_q            <= 4'hf;
      oe_d2_q            <= 4'hf;
      o_group_fault      <= pm_pins_pkg::MASK_RST;
    end else begin
      o_group_health_oe <= self_pull;
      oe_d1_q           <= o_group_health_oe;
      oe_d2_q           <= oe_d1_q;
      // low line that we are not pulling is an outside fault
      // our own pull still sits in the synchroniser for a few cycles after release
      o_group_fault     <= ~health & ~(o_group_health_oe | oe_d1_q | oe_d2_q);
    end
  end
  // hot-swap edges: assert programs, release disconnects
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_prev_q           <= 4'hf;
      o_group_program      <= pm_pins_pkg::MASK_RST;
      o_group_disconnected <= pm_pins_pkg::MASK_RST;
    end else begin
      irq_prev_q           <= irq_n;
      o_group_program      <= hot & irq_prev_q & ~irq_n;
      o_group_disconnected <= (o_group_disconnected & ~(hot & ~irq_n)) | (hot & ~irq_prev_q & irq_n);
    end
  end
  // ----------------------------------------------------------------
  // crowbar and write lock
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_overvoltage_trigger <= 1'b0;
      o_mem_write_en        <= 1'b0;
      o_mem_write_rejected  <= 1'b0;
    end else begin
      o_overvoltage_trigger <= ov;
      // lock pin wins, nothing overrides it
      o_mem_write_en        <= i_mem_write_req & lock_n;
      o_mem_write_rejected  <= i_mem_write_req & ~lock_n;
    end
  end
  // ----------------------------------------------------------------
  // sync/data line
  // ----------------------------------------------------------------
  // data rides on the clock: low phase stretched only when a zero is sent
  logic [7:0] sync_cnt_q;
  logic       sync_phase_q;
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_cnt_q      <= pm_pins_pkg::SYNC_CNT_RST;
      sync_phase_q    <= 1'b0;
      o_sync_data_out <= 1'b0;
      o_sync_data_oe  <= 1'b0;
      o_rx_bit        <= 1'b1;
    end else begin
      // master clock plus data on one open-drain line
      if (sync_cnt_q == 8'(pm_pins_pkg::SYNC_HALF_CYC - 1)) begin
        sync_cnt_q   <= pm_pins_pkg::SYNC_CNT_RST;
        sync_phase_q <= ~sync_phase_q;
        if (sync_phase_q) begin
          o_rx_bit <= sd_in;
        end
      end else begin
        sync_cnt_q <= sync_cnt_q + 8'h01;
      end
      o_sync_data_oe <= ~sync_phase_q | (i_tx_bit_valid & ~i_tx_bit);
    end
  end
endmodule

// [src/pm_pins_pkg.sv]
// package of constants and types for the power manager pin control block
// assumes a 20 MHz system clock and one top module that reads these names
package pm_pins_pkg;
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned N_GROUPS        = 4;
  localparam int unsigned N_AUX           = 4;
  localparam int unsigned ADDR_BITS       = 3;
  // sync clock rate on the sync/data line, arbitrary plain default
  localparam int unsigned SYNC_HZ         = 500000;
  localparam int unsigned SYNC_HALF_CYC   = CLK_HZ / (2 * SYNC_HZ);
  localparam logic [7:0]  SYNC_CNT_RST    = 8'h00;
  // base of the serial-bus address, low three bits come from the strap
  localparam logic [6:0]  BUS_ADDR_BASE   = 7'h58;
  localparam logic [6:0]  BUS_ADDR_RST    = 7'h00;
  // cycles between steps of the sequenced turn-off and turn-on
  localparam int unsigned STEP_CYC        = 16;
  localparam logic [4:0]  STEP_CNT_RST    = 5'h00;
  localparam logic [1:0]  IDX_RST         = 2'h0;
  localparam logic [3:0]  MASK_RST        = 4'h0;
  typedef enum logic [1:0] {
    MODE_HALT,
    MODE_HOT_SWAP
  } irq_mode_t;
  typedef enum {
    ST_COLD,
    ST_PROGRAM,
    ST_RUN,
    ST_SEQ_OFF,
    ST_WAIT_RELEASE,
    ST_SHUTDOWN
  } seq_state_t;
endpackage

// [sim/power_manager_pin_control_sva.sv]
// checker of the pin control block, watching only its top ports
// assumes one clock domain and a strap that stays put while the block runs
module pm_pins_chk (
  input wire logic       i_clk_sys,
  input wire logic       i_reset_n,
  input wire logic       i_cold_restart_n,
  input wire logic       i_mains_loss_n,
  input wire logic       i_write_lock_n,
  input wire logic [2:0] i_addr_strap,
  input wire logic [3:0] i_irq_n,
  input wire logic [3:0] i_irq_hot_swap,
  input wire logic       i_intermediate_bus_over,
  input wire logic       i_mem_write_req,
  input wire logic [6:0] o_bus_addr,
  input wire logic       o_overvoltage_trigger,
  input wire logic [3:0] o_aux_enable,
  input wire logic       o_front_end_on,
  input wire logic [3:0] o_group_health_out,
  input wire logic [3:0] o_group_health_oe,
  input wire logic [3:0] o_group_program,
  input wire logic       o_mem_write_en,
  input wire logic       o_mem_write_rejected,
  input wire logic       o_sync_data_out,
  input wire logic       o_shutdown
);
  timeunit 1ns;
  timeprecision 1ns;
  // cold restart acts as a reset too, so both mute the checks
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n || !i_cold_restart_n);
  // ----------------------------------------
  // pin relations
  // ----------------------------------------
  chk_addr_strap: assert property (i_reset_n [*8] |->
    o_bus_addr == (pm_pins_pkg::BUS_ADDR_BASE | {4'h0, i_addr_strap}))
    else $error("bus address does not match strap");
  chk_crowbar_follow: assert property (i_intermediate_bus_over [*6] |-> o_overvoltage_trigger)
    else $error("crowbar not raised on overvoltage");
  chk_lock_reject: assert property ((!i_write_lock_n) [*6] ##0 i_mem_write_req |=>
    o_mem_write_rejected && !o_mem_write_en)
    else $error("write passed while locked");
  chk_mains_stop: assert property ((!i_mains_loss_n) [*6] |-> o_shutdown)
    else $error("no shutdown on mains loss");
  chk_stop_outputs: assert property (o_shutdown [*2] |-> !o_front_end_on && o_aux_enable == 4'h0)
    else $error("supplies left on in shutdown");
  chk_halt_pull: assert property (($stable(i_irq_n) && $stable(i_irq_hot_swap)) [*6] |->
    (~i_irq_n & ~i_irq_hot_swap & ~o_group_health_oe) == 4'h0)
    else $error("halted group line not pulled low");
  chk_program_pulse: assert property (|o_group_program |=> (o_group_program & $past(o_group_program)) == 4'h0)
    else $error("program pulse longer than one cycle");
  chk_lines_open: assert property (o_group_health_out == 4'h0 && !o_sync_data_out)
    else $error("open-drain line driven high");
endmodule
bind power_manager_pin_control pm_pins_chk chk_u (.*);

// [sim/far_side_model.sv]
// far side: auxiliary devices, faulting converters on the health lines, sync line pull-up
// assumes the bench hands it the block's enables and open-drain enables
module far_side_model (
  input  wire logic       i_clk_sys,
  input  wire logic [3:0] i_aux_enable,
  input  wire logic [3:0] i_health_oe,
  input  wire logic [3:0] i_fault_pull,
  input  wire logic       i_sync_oe,
  input  wire logic       i_slow,
  output logic [3:0]      o_power_good,
  output logic [3:0]      o_health_wire,
  output logic            o_sync_wire
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] lag_q;
  always_ff @(posedge i_clk_sys) begin
    lag_q        <= i_aux_enable;
    o_power_good <= i_slow ? lag_q : i_aux_enable;
  end
  assign o_health_wire = ~(i_health_oe | i_fault_pull);
  assign o_sync_wire = ~i_sync_oe;
endmodule

// [sim/testbench.sv]
// self-checking bench of the pin control block with its far side
// assumes the checker is attached by bind and a 20 MHz clock
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       i_clk_sys = 1'h0, i_reset_n = 1'h0, i_cold_restart_n = 1'h1, i_soft_restart_n = 1'h1;
  logic       i_mains_loss_n = 1'h1, i_write_lock_n = 1'h1, i_intermediate_bus_over = 1'h0, slow = 1'h0;
  logic       i_mem_write_req = 1'h0, i_tx_bit_valid = 1'h0, i_tx_bit = 1'h0, i_sync_data_in;
  logic [2:0] i_addr_strap;
  logic [3:0] i_irq_n = 4'hf, i_irq_hot_swap = 4'h0, fault_pull = 4'h0, i_group_health_in, i_aux_power_good;
  logic [6:0] o_bus_addr;
  logic       o_overvoltage_trigger, o_front_end_on, o_mem_write_en, o_mem_write_rejected;
  logic       o_sync_data_out, o_sync_data_oe, o_rx_bit, o_shutdown, last_oe, tx_force = 1'h0, tx_val = 1'h0;
  logic [3:0] o_aux_enable, o_group_health_out, o_group_health_oe, o_group_fault, o_aux_status;
  logic [3:0] o_group_program, o_group_disconnected, prev;
  logic [1:0] g;
  int         err_total = 0, n_compared = 0, seed = 52427, k, n_tog;
  power_manager_pin_control dut_u (.*);
  far_side_model far_u (.i_clk_sys(i_clk_sys), .i_aux_enable(o_aux_enable), .i_health_oe(o_group_health_oe),
    .i_fault_pull(fault_pull), .i_sync_oe(o_sync_data_oe), .i_slow(slow), .o_power_good(i_aux_power_good),
    .o_health_wire(i_group_health_in), .o_sync_wire(i_sync_data_in));
  always #25 i_clk_sys = ~i_clk_sys;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask
  // each change of the enables must switch exactly the next device in line
  task automatic wait_aux(input logic [3:0] v, input logic up);
    prev = o_aux_enable;
    for (k = 0; k < 400 && o_aux_enable !== v; k++) begin
      @(negedge i_clk_sys);
      if (o_aux_enable !== prev) begin
        check("aux step", up ? {prev[2:0], 1'h1} : {1'h0, prev[3:1]}, o_aux_enable);
        prev = o_aux_enable;
      end
    end
    check("aux wait", v, o_aux_enable);
    if (o_aux_enable !== v) results();
  endtask
  // link traffic keeps the sync line busy with random bits
  always @(posedge i_clk_sys) begin
    i_tx_bit_valid <= tx_force | 1'($random(seed));
    i_tx_bit       <= tx_force ? tx_val : 1'($random(seed));
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    i_addr_strap = 3'($random(seed));
    repeat (8) @(posedge i_clk_sys);
    i_reset_n <= 1'h1;
    wait_aux(4'hf, 1'h1);
    check("bus addr", {1'h0, pm_pins_pkg::BUS_ADDR_BASE | {4'h0, i_addr_strap}}, o_bus_addr);
    check("front end", 8'h01, o_front_end_on);
    n_tog = 0;
    last_oe = o_sync_data_oe;
    for (k = 0; k < 100; k++) begin
      @(negedge i_clk_sys);
      n_tog += (o_sync_data_oe !== last_oe);
      last_oe = o_sync_data_oe;
    end
    check("sync toggling", 8'h01, n_tog > 0);
    // a steady zero holds the line low, a steady one leaves the high phase to the pull-up
    for (int b = 0; b < 2; b++) begin
      @(posedge i_clk_sys);
      tx_force <= 1'h1;
      tx_val   <= b[0];
      settle(100);
      check("rx bit", b[0], o_rx_bit);
    end
    @(posedge i_clk_sys);
    tx_force <= 1'h0;
    check("aux status", 8'h0f, o_aux_status);
    @(posedge i_clk_sys);
    i_intermediate_bus_over <= 1'h1;
    settle(6);
    check("crowbar on", 8'h01, o_overvoltage_trigger);
    for (int lk = 0; lk < 2; lk++) begin
      @(posedge i_clk_sys);
      i_write_lock_n <= lk[0];
      settle(5);
      @(posedge i_clk_sys);
      i_mem_write_req <= 1'h1;
      @(posedge i_clk_sys);
      i_mem_write_req <= 1'h0;
      @(negedge i_clk_sys);
      check("write en", lk[0], o_mem_write_en);
      check("write refused", !lk[0], o_mem_write_rejected);
    end
    @(posedge i_clk_sys);
    slow <= 1'h1;
    i_soft_restart_n <= 1'h0;
    wait_aux(4'h0, 1'h0);
    @(posedge i_clk_sys);
    i_soft_restart_n <= 1'h1;
    wait_aux(4'hf, 1'h1);
    @(posedge i_clk_sys);
    g = 2'($random(seed));
    fault_pull <= 4'h1 << g;
    settle(3);
    check("group fault", 4'h1 << g, o_group_fault);
    for (int m = 0; m < 2; m++) begin
      @(posedge i_clk_sys);
      fault_pull <= 4'h0;
      g = 2'($random(seed));
      i_irq_hot_swap <= 4'(m) << g;
      i_irq_n <= ~(4'h1 << g);
      if (m == 0) begin
        settle(4);
        check("halt pull", 8'h01, o_group_health_oe[g]);
      end else begin
        for (k = 0; k < 8 && o_group_program[g] !== 1'h1; k++) @(negedge i_clk_sys);
        check("program pulse", 8'h01, o_group_program[g]);
      end
      @(posedge i_clk_sys);
      i_irq_n <= 4'hf;
      settle(4);
      if (m == 1) check("disconnected", 8'h01, o_group_disconnected[g]);
    end
    @(posedge i_clk_sys);
    i_mains_loss_n <= 1'h0;
    settle(6);
    check("shutdown", 8'h01, o_shutdown);
    check("front end off", 8'h00, o_front_end_on);
    @(posedge i_clk_sys);
    i_cold_restart_n <= 1'h0;
    settle(4);
    // mains is still lost here, so only the cold restart can clear the shutdown flag
    check("cold shutdown", 8'h00, o_shutdown);
    check("cold front end", 8'h00, o_front_end_on);
    @(posedge i_clk_sys);
    i_cold_restart_n <= 1'h1;
    i_mains_loss_n <= 1'h1;
    wait_aux(4'hf, 1'h1);
    results();
  end
endmodule
